// *** input_parity_alarm_monitor_bench.sv ***
`timescale 1ns/1ps
`include "ipam_regs.svh"
module input_parity_alarm_monitor_bench;
    localparam logic [7:0] ST = `IPAM_OFF_STATUS;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0, cond = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, analog_out_enable, fifo_sync_pulse;
    logic parity_ena = 0, dual_parity = 0, odd_parity = 0;
    logic inject_error = 0, sync_request = 0, word_ready, alarm_seen;
    int num_errors = 0, comparisons = 0, n_sync = 0;
    logic [13:0] ex_t [7] = '{14'h001, 14'h006, 14'h00a, 14'h012,
                              14'h060, 14'h080, 14'h200};
    ipam_if link_if ();
    ipam_device #(.LOSS_CYC(16)) ipam_device_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link_if), .transmit_enable_pin(cond[7]),
        .zero_pattern(cond[0]), .pointers_two_apart_flag(cond[1]),
        .pointers_one_apart_flag(cond[2]), .pointers_equal(cond[3]),
        .conv_clk_lost(cond[4]), .pattern_mismatch(cond[5]),
        .pll_unlocked(cond[6]), .analog_out_enable(analog_out_enable),
        .fifo_sync_pulse(fifo_sync_pulse));
    ipam_source ipam_source_inst (.pclk(pclk), .presetn(presetn),
        .word_valid(1'b1), .word_rise(32'h1234_5678),
        .word_fall(32'h9abc_def0), .word_ready(word_ready),
        .parity_ena(parity_ena), .dual_parity(dual_parity),
        .odd_parity(odd_parity), .inject_error(inject_error),
        .mark_start(1'b0), .sync_request(sync_request),
        .alarm_seen(alarm_seen), .link(link_if));
    ipam_monitor ipam_monitor_inst (.pclk(pclk), .presetn(presetn),
        .data_clk(link_if.data_clk), .first_data_bus(link_if.first_data_bus),
        .second_data_bus(link_if.second_data_bus),
        .input_strobe_lane(link_if.input_strobe_lane),
        .parity_lane(link_if.parity_lane), .sync_lane(link_if.sync_lane),
        .parity_ena(parity_ena), .dual_parity(dual_parity),
        .odd_parity(odd_parity), .inject_error(inject_error));
    always #10 pclk = ~pclk;
    always @(posedge pclk)
        if (fifo_sync_pulse === 1'b1) n_sync <= n_sync + 1;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] ex, got);
        comparisons++;
        if (got !== ex) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] ex, string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask : rchk
    task automatic t_regs;
        rchk(`IPAM_OFF_TEST_CTRL, 32'h10, "ctrl");
        rchk(`IPAM_OFF_SHUTOFF, 32'h0, "shutoff");
        rchk(ST, 32'h0, "status");
        rchk(`IPAM_OFF_MASK, 32'h3fff, "mask");
        rchk(`IPAM_OFF_SYNC_SEL, 32'h1, "syncsel");
        apb(1'b1, 8'h14, 32'h1);
        chk("unmapped err", 32'h1, {31'h0, er});
        rchk(8'h14, 32'h0, "unmapped");
    endtask : t_regs
    task automatic t_alarms;
        cond[6] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("masked pin", 32'h0, {31'h0, alarm_seen});
        cond[6] <= 1'b0;
        rchk(ST, 32'h200, "masked bit");
        apb(1'b1, `IPAM_OFF_MASK, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ST, 32'h0);
            cond[i] <= 1'b1;
            repeat (8) @(posedge pclk);
            apb(1'b1, ST, 32'h0);
            repeat (4) @(posedge pclk);
            rchk(ST, {18'h0, ex_t[i]}, "held");
            chk("pin", 32'h1, {31'h0, alarm_seen});
            cond[i] <= 1'b0;
            repeat (8) @(posedge pclk);
            rchk(ST, {18'h0, ex_t[i]}, "sticky");
            apb(1'b1, ST, 32'h0);
            repeat (8) @(posedge pclk);
            rchk(ST, 32'h0, "cleared");
            chk("pin low", 32'h0, {31'h0, alarm_seen});
        end
    endtask : t_alarms
    task automatic t_shut;
        cond[7] <= 1'b1;
        apb(1'b1, `IPAM_OFF_SHUTOFF, 32'h1);
        repeat (8) @(posedge pclk);
        chk("out on", 32'h1, {31'h0, analog_out_enable});
        cond[4] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("out off", 32'h0, {31'h0, analog_out_enable});
        cond[4] <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, ST, 32'h0);
        repeat (8) @(posedge pclk);
        chk("out back", 32'h1, {31'h0, analog_out_enable});
        apb(1'b1, `IPAM_OFF_TEST_CTRL, 32'h18);
        cond[6:5] <= 2'b11;
        repeat (8) @(posedge pclk);
        rchk(ST, 32'h80, "test view");
        chk("out test", 32'h0, {31'h0, analog_out_enable});
        cond[6:5] <= 2'b00;
    endtask : t_shut
    task automatic t_par(input logic [31:0] c, input logic dl, od,
                         input logic [13:0] e);
        int n0;
        n0 = n_sync;
        parity_ena <= 1'b1;
        dual_parity <= dl;
        odd_parity <= od;
        sync_request <= 1'b1;
        @(posedge pclk);
        sync_request <= 1'b0;
        apb(1'b1, `IPAM_OFF_TEST_CTRL, c);
        apb(1'b1, `IPAM_OFF_SYNC_SEL, 32'h3);
        repeat (40) @(posedge pclk);
        apb(1'b1, ST, 32'h0);
        repeat (24) @(posedge pclk);
        rchk(ST, 32'h0, "clean");
        inject_error <= 1'b1;
        repeat (16) @(posedge pclk);
        inject_error <= 1'b0;
        repeat (16) @(posedge pclk);
        rchk(ST, {18'h0, e}, "parity");
        chk("fifo sync", n0 + 1, n_sync);
    endtask : t_par
    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_alarms;
        t_shut;
        t_par(32'h17, 1'b1, 1'b1, 14'h3c00);
        t_par(32'h11, 1'b0, 1'b0, 14'h0c00);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        complete_run;
    end
endmodule : input_parity_alarm_monitor_bench

// *** ipam_device.sv ***
`timescale 1ns/1ps
`include "ipam_regs.svh"

module ipam_device #(
    parameter int ADDR_W   = 8,
    parameter int LOSS_CYC = `IPAM_DCLK_LOSS_CYC
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Data link
    ipam_if.device                 link,
    // Converter-side conditions, asynchronous levels
    input  wire logic              transmit_enable_pin,
    input  wire logic              zero_pattern,
    input  wire logic              pointers_two_apart_flag,
    input  wire logic              pointers_one_apart_flag,
    input  wire logic              pointers_equal,
    input  wire logic              conv_clk_lost,
    input  wire logic              pattern_mismatch,
    input  wire logic              pll_unlocked,
    // Results
    output logic                   analog_out_enable,
    output logic                   fifo_sync_pulse
);

    localparam int LW = 36;
    localparam int EW = 8;
    localparam logic [15:0] LOSS_MAX = 16'(LOSS_CYC);

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [LW-1:0] meta_link;
    logic [LW-1:0] sync_link;
    logic [EW-1:0] meta_evt;
    logic [EW-1:0] sync_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_link <= '0;
            sync_link <= '0;
        end else begin
            meta_link <= {link.data_clk, link.first_data_bus,
                          link.second_data_bus, link.input_strobe_lane,
                          link.parity_lane, link.sync_lane};
            sync_link <= meta_link;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_evt <= '0;
            sync_evt <= '0;
        end else begin
            meta_evt <= {transmit_enable_pin, zero_pattern,
                         pointers_two_apart_flag, pointers_one_apart_flag,
                         pointers_equal, conv_clk_lost, pattern_mismatch,
                         pll_unlocked};
            sync_evt <= meta_evt;
        end
    end

    logic        dclk;
    logic [15:0] first_bus;
    logic [15:0] second_bus;
    logic        strobe;
    logic        parity;
    logic        sync_ln;
    assign {dclk, first_bus, second_bus, strobe, parity, sync_ln} = sync_link;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [`IPAM_TC_W-1:0] test_ctrl;
    logic [1:0]            shutoff;
    logic [`IPAM_AL_W-1:0] status;
    logic [`IPAM_AL_W-1:0] mask;
    logic [1:0]            sync_sel;

    logic parity_ena;
    logic dual_mode;
    logic odd_sel;
    logic iotest_ena;
    assign parity_ena = test_ctrl[`IPAM_TC_PARITY_ENA];
    assign odd_sel    = test_ctrl[`IPAM_TC_ODD_PARITY];
    assign iotest_ena = test_ctrl[`IPAM_TC_IOTEST_ENA];
    assign dual_mode  = parity_ena & test_ctrl[`IPAM_TC_DUAL_PARITY];

    // ------------------------------------------------------------------
    // Data clock edges and loss
    // ------------------------------------------------------------------
    logic        dclk_q;
    logic        strobe_q;
    logic        sync_q;
    logic [15:0] idle_cnt;
    logic        rise;
    logic        fall;
    logic        dclk_gone;

    assign rise      = dclk & ~dclk_q;
    assign fall      = ~dclk & dclk_q;
    assign dclk_gone = (idle_cnt >= LOSS_MAX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dclk_q   <= 1'b0;
            strobe_q <= 1'b0;
            sync_q   <= 1'b0;
        end else begin
            dclk_q   <= dclk;
            strobe_q <= strobe;
            sync_q   <= sync_ln;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt <= '0;
        end else if (rise | fall) begin
            idle_cnt <= '0;
        end else if (!dclk_gone) begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Parity checks
    // ------------------------------------------------------------------
    logic err_first;
    logic err_second;
    logic err_word;

    assign err_first  = ipam_pkg::ipam_lane_parity(
                            {16'h0000, first_bus, strobe}, odd_sel);
    assign err_second = ipam_pkg::ipam_lane_parity(
                            {16'h0000, second_bus, parity}, odd_sel);
    assign err_word   = ipam_pkg::ipam_lane_parity(
                            {first_bus, second_bus, parity}, odd_sel);

    // ------------------------------------------------------------------
    // Alarm events
    // ------------------------------------------------------------------
    logic [`IPAM_AL_W-1:0] set_vec;
    logic                  err_path1;

    assign err_path1 = dual_mode ? err_first : err_word;

    always_comb begin
        set_vec = '0;
        set_vec[`IPAM_AL_ZERO]      = sync_evt[6];
        set_vec[`IPAM_AL_TWO_APART] = sync_evt[5];
        set_vec[`IPAM_AL_ONE_APART] = sync_evt[4];
        set_vec[`IPAM_AL_COLLISION] = sync_evt[3];
        set_vec[`IPAM_AL_FIFO]      = |sync_evt[5:3];
        set_vec[`IPAM_AL_CONV_GONE] = sync_evt[2];
        set_vec[`IPAM_AL_DCLK_GONE] = dclk_gone;
        set_vec[`IPAM_AL_CLK_GONE]  = sync_evt[2] | dclk_gone;
        set_vec[`IPAM_AL_PATTERN]   = sync_evt[1];
        set_vec[`IPAM_AL_PLL]       = sync_evt[0];
        set_vec[`IPAM_AL_PAR_A] = parity_ena & rise & err_path1;
        set_vec[`IPAM_AL_PAR_B] = parity_ena & fall & err_path1;
        set_vec[`IPAM_AL_PAR_C] = dual_mode & rise & err_second;
        set_vec[`IPAM_AL_PAR_D] = dual_mode & fall & err_second;
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    function automatic logic ipam_hit(input logic [ADDR_W-1:0] a);
        ipam_hit = (a == ADDR_W'(`IPAM_OFF_TEST_CTRL)) |
                   (a == ADDR_W'(`IPAM_OFF_SHUTOFF))   |
                   (a == ADDR_W'(`IPAM_OFF_STATUS))    |
                   (a == ADDR_W'(`IPAM_OFF_MASK))      |
                   (a == ADDR_W'(`IPAM_OFF_SYNC_SEL));
    endfunction : ipam_hit

    logic                  wr;
    logic [`IPAM_AL_W-1:0] view;
    logic [`IPAM_AL_W-1:0] keep;
    logic [31:0]           next_prdata;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~ipam_hit(paddr);
    assign wr      = psel & penable & pwrite & ipam_hit(paddr);

    // Test mode hides all but the pattern alarm
    assign view = iotest_ena ? (status & (`IPAM_AL_W'(1) << `IPAM_AL_PATTERN))
                             : status;

    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            ADDR_W'(`IPAM_OFF_TEST_CTRL): next_prdata = 32'(test_ctrl);
            ADDR_W'(`IPAM_OFF_SHUTOFF):   next_prdata = 32'(shutoff);
            ADDR_W'(`IPAM_OFF_STATUS):    next_prdata = 32'(view);
            ADDR_W'(`IPAM_OFF_MASK):      next_prdata = 32'(mask);
            ADDR_W'(`IPAM_OFF_SYNC_SEL):  next_prdata = 32'(sync_sel);
            default:                      next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_ctrl <= `IPAM_TC_RESET;
            shutoff   <= `IPAM_SO_RESET;
            mask      <= `IPAM_MASK_RESET;
            sync_sel  <= `IPAM_SS_RESET;
        end else if (wr) begin
            case (paddr)
                ADDR_W'(`IPAM_OFF_TEST_CTRL): test_ctrl <= pwdata[`IPAM_TC_W-1:0];
                ADDR_W'(`IPAM_OFF_SHUTOFF):   shutoff   <= pwdata[1:0];
                ADDR_W'(`IPAM_OFF_MASK):      mask      <= pwdata[`IPAM_AL_W-1:0];
                ADDR_W'(`IPAM_OFF_SYNC_SEL):  sync_sel  <= pwdata[1:0];
                default:                      ;
            endcase
        end
    end

    // Written zeros clear; a new event in the same cycle wins
    assign keep = (wr && paddr == ADDR_W'(`IPAM_OFF_STATUS))
                ? pwdata[`IPAM_AL_W-1:0] : {`IPAM_AL_W{1'b1}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= (status & keep) | set_vec;
        end
    end

    // ------------------------------------------------------------------
    // Alarm pin, output shut-off, FIFO sync
    // ------------------------------------------------------------------
    logic shut;
    assign shut = (shutoff[`IPAM_SO_CLOCK]     & status[`IPAM_AL_CLK_GONE]) |
                  (shutoff[`IPAM_SO_COLLISION] & status[`IPAM_AL_COLLISION]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.alarm <= 1'b0;
        end else begin
            link.alarm <= |(view & ~mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_out_enable <= 1'b0;
        end else begin
            analog_out_enable <= sync_evt[7] & test_ctrl[`IPAM_TC_TX_ENABLE]
                               & ~iotest_ena & ~shut;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_sync_pulse <= 1'b0;
        end else begin
            fifo_sync_pulse <=
                (sync_sel[`IPAM_SS_SYNC_LANE] & sync_ln & ~sync_q) |
                (sync_sel[`IPAM_SS_STROBE] & ~dual_mode
                 & strobe & ~strobe_q);
        end
    end

endmodule : ipam_device

// *** ipam_if.sv ***
`timescale 1ns/1ps
interface ipam_if;
    logic        data_clk;
    logic [15:0] first_data_bus;
    logic [15:0] second_data_bus;
    logic        input_strobe_lane;
    logic        parity_lane;
    logic        sync_lane;
    logic        alarm;

    modport device (
        input  data_clk,
        input  first_data_bus,
        input  second_data_bus,
        input  input_strobe_lane,
        input  parity_lane,
        input  sync_lane,
        output alarm
    );

    modport source (
        output data_clk,
        output first_data_bus,
        output second_data_bus,
        output input_strobe_lane,
        output parity_lane,
        output sync_lane,
        input  alarm
    );
endinterface : ipam_if

// *** ipam_monitor.sv ***
`timescale 1ns/1ps
module ipam_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Link
    input wire logic        data_clk,
    input wire logic [15:0] first_data_bus,
    input wire logic [15:0] second_data_bus,
    input wire logic        input_strobe_lane,
    input wire logic        parity_lane,
    input wire logic        sync_lane,
    // Source modes
    input wire logic        parity_ena,
    input wire logic        dual_parity,
    input wire logic        odd_parity,
    input wire logic        inject_error
);
    logic [15:0] hist;
    logic [3:0]  cfg;
    logic        ok;
    logic [33:0] ln;
    assign cfg = {parity_ena, dual_parity, odd_parity, inject_error};
    assign ok  = hist == {4{cfg}} && parity_ena && !inject_error;
    assign ln  = {first_data_bus, second_data_bus, input_strobe_lane,
                  parity_lane};
    // Modes unchanged over the last four cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hist <= '0;
        else hist <= {hist[11:0], cfg};
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    high_half_a: assert property (
        $rose(data_clk) |-> data_clk[*4] ##1 !data_clk) else $error("high");
    low_half_a: assert property (
        $fell(data_clk) |-> !data_clk[*4] ##1 data_clk) else $error("low");
    hold_before_a: assert property (
        $changed(data_clk) |-> $stable(ln)) else $error("setup");
    hold_after_a: assert property (
        $changed(data_clk) |=> $stable(ln)) else $error("hold");
    path_one_a: assert property (
        ok && dual_parity && $changed(data_clk) |->
        (^{first_data_bus, input_strobe_lane}) == odd_parity)
        else $error("path one");
    path_two_a: assert property (
        ok && dual_parity && $changed(data_clk) |->
        (^{second_data_bus, parity_lane}) == odd_parity)
        else $error("path two");
    single_word_a: assert property (
        ok && !dual_parity && $changed(data_clk) |->
        (^{first_data_bus, second_data_bus, parity_lane}) == odd_parity)
        else $error("single");
    sync_frame_a: assert property (
        $rose(sync_lane) |-> sync_lane[*8] ##1 !sync_lane) else $error("sync");
endmodule : ipam_monitor

// *** ipam_pkg.sv ***
package ipam_pkg;

    // Source-side link phase, each lasting half of a half period
    typedef enum logic [1:0] {
        IPAM_LOAD_RISE,
        IPAM_RAISE,
        IPAM_LOAD_FALL,
        IPAM_LOWER
    } ipam_phase_e;

    // Parity bit that completes a path; on a full path, 1 means error
    function automatic logic ipam_lane_parity(input logic [32:0] bits,
                                              input logic        odd);
        ipam_lane_parity = (^bits) ^ odd;
    endfunction : ipam_lane_parity

endpackage : ipam_pkg

// *** ipam_regs.svh ***
`ifndef IPAM_REGS_SVH
`define IPAM_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IPAM_OFF_TEST_CTRL   8'h00
`define IPAM_OFF_SHUTOFF     8'h04
`define IPAM_OFF_STATUS      8'h08
`define IPAM_OFF_MASK        8'h0c
`define IPAM_OFF_SYNC_SEL    8'h10

// ----------------------------------------------------------------------
// input_test_control_reg fields
// ----------------------------------------------------------------------
`define IPAM_TC_PARITY_ENA   0
`define IPAM_TC_DUAL_PARITY  1
`define IPAM_TC_ODD_PARITY   2
`define IPAM_TC_IOTEST_ENA   3
`define IPAM_TC_TX_ENABLE    4
`define IPAM_TC_W            5
`define IPAM_TC_RESET        5'h10

// ----------------------------------------------------------------------
// auto_shutoff_control_reg and sync_source_select_reg fields
// ----------------------------------------------------------------------
`define IPAM_SO_CLOCK        0
`define IPAM_SO_COLLISION    1
`define IPAM_SO_RESET        2'h0
`define IPAM_SS_SYNC_LANE    0
`define IPAM_SS_STROBE       1
`define IPAM_SS_RESET        2'h1

// ----------------------------------------------------------------------
// alarm_status_reg and alarm_mask_reg bit positions
// ----------------------------------------------------------------------
`define IPAM_AL_ZERO         0
`define IPAM_AL_FIFO         1
`define IPAM_AL_TWO_APART    2
`define IPAM_AL_ONE_APART    3
`define IPAM_AL_COLLISION    4
`define IPAM_AL_CLK_GONE     5
`define IPAM_AL_CONV_GONE    6
`define IPAM_AL_PATTERN      7
`define IPAM_AL_DCLK_GONE    8
`define IPAM_AL_PLL          9
`define IPAM_AL_PAR_A        10
`define IPAM_AL_PAR_B        11
`define IPAM_AL_PAR_C        12
`define IPAM_AL_PAR_D        13
`define IPAM_AL_W            14
`define IPAM_MASK_RESET      14'h3fff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IPAM_CLK_PERIOD_NS   20
`define IPAM_LINK_HALF_NS    80
`define IPAM_LINK_HALF_CYC   ((`IPAM_LINK_HALF_NS) / (`IPAM_CLK_PERIOD_NS))
`define IPAM_DCLK_LOSS_CYC   64

`endif

// *** ipam_source.sv ***
`timescale 1ns/1ps
`include "ipam_regs.svh"

module ipam_source #(
    parameter int HALF_CYC = `IPAM_LINK_HALF_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Word pair request
    input  wire logic        word_valid,
    input  wire logic [31:0] word_rise,
    input  wire logic [31:0] word_fall,
    output logic             word_ready,
    // Mode and control levels
    input  wire logic        parity_ena,
    input  wire logic        dual_parity,
    input  wire logic        odd_parity,
    input  wire logic        inject_error,
    input  wire logic        mark_start,
    input  wire logic        sync_request,
    // Alarm seen from the device
    output logic             alarm_seen,
    // Data link
    ipam_if.source           link
);

    localparam int          SUB   = (HALF_CYC / 2 < 1) ? 1 : HALF_CYC / 2;
    localparam logic [15:0] SUB_M = 16'(SUB - 1);

    // ------------------------------------------------------------------
    // Phase sequencer, data clock divider
    // ------------------------------------------------------------------
    ipam_pkg::ipam_phase_e phase;
    logic [15:0]           cnt;
    logic                  step;
    logic [31:0]           fall_hold;
    logic                  mark_pend;
    logic                  sync_pend;
    logic                  dual;
    logic [31:0]           w;
    logic                  load;
    logic                  meta_alarm;

    assign step       = (cnt == SUB_M);
    assign word_ready = step & (phase == ipam_pkg::IPAM_LOWER);
    assign dual       = parity_ena & dual_parity;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt   <= '0;
            phase <= ipam_pkg::IPAM_LOAD_RISE;
        end else if (step) begin
            cnt <= '0;
            case (phase)
                ipam_pkg::IPAM_LOAD_RISE: phase <= ipam_pkg::IPAM_RAISE;
                ipam_pkg::IPAM_RAISE:     phase <= ipam_pkg::IPAM_LOAD_FALL;
                ipam_pkg::IPAM_LOAD_FALL: phase <= ipam_pkg::IPAM_LOWER;
                ipam_pkg::IPAM_LOWER:     phase <= ipam_pkg::IPAM_LOAD_RISE;
                default:                  phase <= ipam_pkg::IPAM_LOAD_RISE;
            endcase
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.data_clk <= 1'b0;
        end else if (step && phase == ipam_pkg::IPAM_LOAD_RISE) begin
            link.data_clk <= 1'b1;
        end else if (step && phase == ipam_pkg::IPAM_LOAD_FALL) begin
            link.data_clk <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Word and lane drive
    // ------------------------------------------------------------------
    assign load = step & ((phase == ipam_pkg::IPAM_LOWER) |
                          (phase == ipam_pkg::IPAM_RAISE));
    assign w = (phase == ipam_pkg::IPAM_LOWER)
             ? (word_valid ? word_rise : 32'h0000_0000) : fall_hold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_hold <= 32'h0000_0000;
        end else if (word_ready) begin
            fall_hold <= word_valid ? word_fall : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mark_pend <= 1'b0;
            sync_pend <= 1'b0;
        end else begin
            mark_pend <= mark_start | (mark_pend & ~word_ready);
            sync_pend <= sync_request | (sync_pend & ~word_ready);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.first_data_bus    <= 16'h0000;
            link.second_data_bus   <= 16'h0000;
            link.input_strobe_lane <= 1'b0;
            link.parity_lane       <= 1'b0;
        end else if (load) begin
            link.first_data_bus  <= w[15:0];
            link.second_data_bus <= w[31:16];
            if (dual) begin
                link.input_strobe_lane <= inject_error ^
                    ipam_pkg::ipam_lane_parity({17'h0_0000, w[15:0]},
                                               odd_parity);
                link.parity_lane <= inject_error ^
                    ipam_pkg::ipam_lane_parity({17'h0_0000, w[31:16]},
                                               odd_parity);
            end else begin
                link.input_strobe_lane <= mark_pend &
                                          (phase == ipam_pkg::IPAM_LOWER);
                link.parity_lane <= inject_error ^
                    ipam_pkg::ipam_lane_parity({1'b0, w}, odd_parity);
            end
        end
    end

    // Sync lane is the FIFO sync, so dual parity keeps working
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.sync_lane <= 1'b0;
        end else if (word_ready) begin
            link.sync_lane <= sync_pend;
        end
    end

    // ------------------------------------------------------------------
    // Alarm pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_alarm <= 1'b0;
            alarm_seen <= 1'b0;
        end else begin
            meta_alarm <= link.alarm;
            alarm_seen <= meta_alarm;
        end
    end

endmodule : ipam_source
